// ---- logic/por_reset_sequencer.sv ----
// power-on reset sequencer: reset outputs and strap pin release
// assumes power_on_reset_n and straps are synchronous to ref_clk_in
// Functional notes
// - hard and soft reset held 512 sync periods
// - soft reset stays 16 periods after hard
// - release strap pins when hard reset asserts
// - redrive strap pins one period after release
// - wait 100 us pll lock first
// - straps: three source bits plus divide bit
// - host mode sync period follows divide cfg
`timescale 1ns/1ps
module por_reset_sequencer
	import rst_seq_pkg::*;
#(
	parameter int unsigned PLL_WAIT = PLL_LOCK_CYC  // shorten in sim
)
(
	input  wire logic       ref_clk_in,            // reference clock
	input  wire logic       arst_n_in,             // async reset
	input  wire logic       clk_en_in,             // freeze when low
	input  wire logic       power_on_reset_n_in,   // supervisor por
	input  wire logic [2:0] reset_source_select_in, // strap input side
	input  wire logic       input_clock_divide_cfg_in, // strap input
	input  wire logic [3:0] cfg_drive_val_in,      // value when redriven
	output logic            hard_reset_n_out,      // hard reset drive
	output logic            hard_reset_n_oe_out,   // hard reset enable
	output logic            soft_reset_n_out,      // soft reset drive
	output logic            soft_reset_n_oe_out,   // soft reset enable
	output logic [3:0]      cfg_pins_out,          // strap pin drive
	output logic            cfg_pins_oe_out,       // strap pin enable
	output logic [2:0]      reset_source_out,      // latched source
	output logic            clock_divide_out,      // latched divide
	output logic            pll_locked_out         // pll wait done
);
	logic [1:0]       rst_sync_q;  // reset release stages
	logic             rst_n;       // synchronised reset
	seq_state_t       st_q;        // sequencer phase
	seq_state_t       st_d;        // next phase
	logic [CNT_W-1:0] cnt_q;       // sync period counter
	logic [17:0]      pll_q;       // pll wait counter
	logic             por_q;       // por seen last cycle
	logic             tick;        // one sync period elapsed
	logic [2:0]       src_q;       // latched source select
	logic             div_q;       // latched divide cfg
	logic [11:0]      hold_q;      // check: cycles with hard reset pulled
	logic [5:0]       gap_q;       // check: cycles from hard to soft release

	// whole-period test: the first tick after a phase change may close
	// only part of a period, so one extra tick guarantees whole periods
	function automatic logic periods_done(input logic tick_v,
		input logic [CNT_W-1:0] cnt_v, input int unsigned periods);
		return tick_v && cnt_v == CNT_W'(periods);
	endfunction : periods_done

	// reference cycles in one sync period for a divide setting
	function automatic int unsigned sync_cycles(input logic div_sel);
		return 32'(div_sel ? DIV_RATIO_2 : DIV_RATIO_1) + 32'h1;
	endfunction : sync_cycles

	// reset release through two stages; async assert
	always_ff @(posedge ref_clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
			rst_sync_q <= 2'b00;
		else
			rst_sync_q <= {rst_sync_q[0], 1'b1};
	end
	assign rst_n = rst_sync_q[1];

	// sync period tick, period from latched divide cfg
	sync_tick_gen u_tick (
		.ref_clk_in (ref_clk_in),
		.rst_n_in   (rst_n),
		.clk_en_in  (clk_en_in),
		.div_sel_in (div_q),
		.tick_out   (tick)
	);

	// por edge tracking for strap capture
	always_ff @(posedge ref_clk_in or negedge rst_n)
	begin
		if (!rst_n)
			por_q <= 1'b0;
		else if (clk_en_in)
			por_q <= power_on_reset_n_in;
	end

	// straps latched once on por rising; setup is the board's job
	always_ff @(posedge ref_clk_in or negedge rst_n)
	begin
		if (!rst_n)
		begin
			src_q <= SRC_RESET_VAL;
			div_q <= DIV_RESET_VAL;
		end
		else if (clk_en_in && power_on_reset_n_in && !por_q)
		begin
			src_q <= reset_source_select_in;
			div_q <= input_clock_divide_cfg_in;
		end
	end

	// next phase; por low forces restart, taken by the phase register only while clk_en_in is high
	always_comb
	begin
		st_d = st_q;
		unique case (st_q)
			ST_POR:
				if (power_on_reset_n_in)
					st_d = ST_PLL;
			ST_PLL:
				if (pll_q >= 18'(PLL_WAIT))
					st_d = ST_HARD;
			ST_HARD:
				if (periods_done(tick, cnt_q, HOLD_PERIODS))
					st_d = ST_SOFT;
			ST_SOFT:
				if (periods_done(tick, cnt_q, SOFT_TAIL))
					st_d = ST_REDRIVE;
			ST_REDRIVE:
				if (periods_done(tick, cnt_q, REDRIVE_WAIT))
					st_d = ST_RUN;
			ST_RUN:
				st_d = ST_RUN;
			default:
				st_d = ST_POR;
		endcase
		if (!power_on_reset_n_in)
			st_d = ST_POR;
	end

	// phase register
	always_ff @(posedge ref_clk_in or negedge rst_n)
	begin
		if (!rst_n)
			st_q <= ST_POR;
		else if (clk_en_in)
			st_q <= st_d;
	end

	// sync period counter, cleared on each phase change
	always_ff @(posedge ref_clk_in or negedge rst_n)
	begin
		if (!rst_n)
			cnt_q <= '0;
		else if (clk_en_in)
		begin
			if (st_d != st_q)
				cnt_q <= '0;
			else if (tick)
				cnt_q <= cnt_q + 1'b1;
		end
	end

	// pll wait counter, counts reference cycles in ST_PLL
	always_ff @(posedge ref_clk_in or negedge rst_n)
	begin
		if (!rst_n)
			pll_q <= '0;
		else if (clk_en_in)
		begin
			if (st_q != ST_PLL)
				pll_q <= '0;
			else if (pll_q < 18'(PLL_WAIT))
				pll_q <= pll_q + 1'b1;
		end
	end

	// reset outputs: driven low while asserted, released after
	always_ff @(posedge ref_clk_in or negedge rst_n)
	begin
		if (!rst_n)
		begin
			hard_reset_n_out    <= 1'b0;
			hard_reset_n_oe_out <= 1'b1;
			soft_reset_n_out    <= 1'b0;
			soft_reset_n_oe_out <= 1'b1;
			pll_locked_out      <= 1'b0;
		end
		else if (clk_en_in)
		begin
			// open drain: enable only while pulling low
			hard_reset_n_out    <= 1'b0;
			hard_reset_n_oe_out <= (st_d == ST_POR || st_d == ST_PLL ||
				st_d == ST_HARD);
			soft_reset_n_out    <= 1'b0;
			soft_reset_n_oe_out <= (st_d != ST_REDRIVE &&
				st_d != ST_RUN);
			pll_locked_out      <= (st_d != ST_POR && st_d != ST_PLL);
		end
	end

	// strap pins: floated in reset so board straps win
	always_ff @(posedge ref_clk_in or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cfg_pins_out    <= 4'h0;
			cfg_pins_oe_out <= 1'b0;
		end
		else if (clk_en_in)
		begin
			cfg_pins_out    <= cfg_drive_val_in;
			cfg_pins_oe_out <= (st_d == ST_RUN);
		end
	end

	// latched strap values exported
	always_ff @(posedge ref_clk_in or negedge rst_n)
	begin
		if (!rst_n)
		begin
			reset_source_out <= SRC_RESET_VAL;
			clock_divide_out <= DIV_RESET_VAL;
		end
		else if (clk_en_in)
		begin
			reset_source_out <= src_q;
			clock_divide_out <= div_q;
		end
	end

	// check helpers: measured hard hold and hard to soft gap, saturating
	always_ff @(posedge ref_clk_in or negedge rst_n)
	begin
		if (!rst_n)
		begin
			hold_q <= '0;
			gap_q  <= '0;
		end
		else if (clk_en_in)
		begin
			if (!hard_reset_n_oe_out)
				hold_q <= '0;
			else if (hold_q != '1)
				hold_q <= hold_q + 1'b1;
			if (hard_reset_n_oe_out)
				gap_q <= '0;
			else if (soft_reset_n_oe_out && gap_q != '1)
				gap_q <= gap_q + 1'b1;
		end
	end

	// checks
	sequence hard_rel_s;
		$rose(hard_reset_n_oe_out == 1'b0);
	endsequence

	chk_soft_after_hard: assert property (
		@(posedge ref_clk_in) disable iff (!rst_n)
		hard_rel_s |-> soft_reset_n_oe_out [*8])
		else $error("soft reset released too soon");
	chk_pins_float_hard: assert property (
		@(posedge ref_clk_in) disable iff (!rst_n)
		hard_reset_n_oe_out |-> !cfg_pins_oe_out)
		else $error("strap pins driven in hard reset");
	chk_redrive_gap: assert property (
		@(posedge ref_clk_in) disable iff (!rst_n)
		$rose(cfg_pins_oe_out) |-> $past(!soft_reset_n_oe_out, 1))
		else $error("strap pins redriven too early");
	chk_hard_min_hold: assert property (
		@(posedge ref_clk_in) disable iff (!rst_n)
		(st_q == ST_HARD && st_d == ST_SOFT) |->
		cnt_q == CNT_W'(HOLD_PERIODS))
		else $error("hard reset hold short");
	chk_pll_wait: assert property (
		@(posedge ref_clk_in) disable iff (!rst_n)
		(st_q == ST_PLL && st_d == ST_HARD) |-> pll_q >= 18'(PLL_WAIT))
		else $error("pll wait cut short");
	chk_strap_hold: assert property (
		@(posedge ref_clk_in) disable iff (!rst_n)
		(clk_en_in && por_q && power_on_reset_n_in) |=> $stable(src_q))
		else $error("strap latch changed");
	chk_div_follow: assert property (
		@(posedge ref_clk_in) disable iff (!rst_n)
		(clk_en_in && div_q && tick && $stable(div_q)) |=> !tick)
		else $error("sync period ignores divide cfg");
	chk_por_restart: assert property (
		@(posedge ref_clk_in) disable iff (!rst_n)
		(clk_en_in && !power_on_reset_n_in) |=>
		hard_reset_n_oe_out && soft_reset_n_oe_out)
		else $error("por did not force reset");
	chk_hard_hold_len: assert property (
		@(posedge ref_clk_in) disable iff (!rst_n)
		$fell(hard_reset_n_oe_out) |->
		32'(hold_q) >= HOLD_PERIODS * sync_cycles(div_q))
		else $error("hard reset held too briefly");
	chk_soft_tail_len: assert property (
		@(posedge ref_clk_in) disable iff (!rst_n)
		$fell(soft_reset_n_oe_out) |->
		32'(gap_q) >= SOFT_TAIL * sync_cycles(div_q))
		else $error("soft reset tail too short");
endmodule : por_reset_sequencer

// ---- logic/rst_seq_pkg.sv ----
// constants for the power-on reset sequencer
// assumes a 20 MHz reference clock feeding the whole block
package rst_seq_pkg;
	localparam int unsigned CLK_PERIOD_NS   = 50;   // reference clock period
	localparam int unsigned HOLD_PERIODS    = 512;  // min reset assertion
	localparam int unsigned SOFT_TAIL       = 16;   // hard to soft gap
	localparam int unsigned REDRIVE_WAIT    = 1;    // sync periods to redrive
	localparam int unsigned PLL_LOCK_US     = 100;  // longest pll lock time
	// pll wait rounded up to whole reference cycles
	localparam int unsigned PLL_LOCK_CYC    =
		(PLL_LOCK_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned CNT_W           = 12;   // phase counter width
	localparam int unsigned DIV_W           = 4;    // sync divider width
	localparam logic [2:0]  SRC_RESET_VAL   = 3'h0; // source select at reset
	localparam logic        DIV_RESET_VAL   = 1'h0; // divide cfg at reset
	localparam logic [3:0]  DIV_RATIO_1     = 4'h0; // sync tick every clock
	localparam logic [3:0]  DIV_RATIO_2     = 4'h1; // sync tick every 2nd

	// gray-coded sequencer phases
	typedef enum logic [2:0] {
		ST_POR     = 3'b000,
		ST_PLL     = 3'b001,
		ST_HARD    = 3'b011,
		ST_SOFT    = 3'b010,
		ST_REDRIVE = 3'b110,
		ST_RUN     = 3'b111
	} seq_state_t;
endpackage : rst_seq_pkg

// ---- logic/sync_tick_gen.sv ----
// sync clock period tick generator
// assumes inputs are synchronous to ref_clk_in
`timescale 1ns/1ps
module sync_tick_gen
	import rst_seq_pkg::*;
(
	input  wire logic ref_clk_in,   // reference clock
	input  wire logic rst_n_in,     // synchronised reset
	input  wire logic clk_en_in,    // freeze when low
	input  wire logic div_sel_in,   // latched divide cfg
	output logic      tick_out      // one pulse per sync period
);
	logic [DIV_W-1:0] cnt_q;   // period counter
	logic [DIV_W-1:0] limit;   // terminal count

	// divide cfg picks the sync period in host mode
	assign limit = div_sel_in ? DIV_RATIO_2 : DIV_RATIO_1;

	// count reference cycles, pulse at the end of each period
	always_ff @(posedge ref_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			cnt_q    <= '0;
			tick_out <= 1'b0;
		end
		else if (clk_en_in)
		begin
			tick_out <= (cnt_q == limit);
			cnt_q    <= (cnt_q == limit) ? '0 : cnt_q + 1'b1;
		end
	end
endmodule : sync_tick_gen

// ---- sim/board_supervisor.sv ----
// board reset supervisor and strap logic model
// assumes ref_clk_in is the sequencer reference clock
`timescale 1ns/1ps
module board_supervisor
(
	input  wire logic       ref_clk_in, // reference clock
	input  wire logic       go_in,      // supplies stable
	input  wire logic [2:0] src_in,     // wanted source straps
	input  wire logic       div_in,     // wanted divide strap
	output logic            por_n_out,  // power-on reset
	output logic [2:0]      src_out,    // source strap levels
	output logic            div_out     // divide strap level
);
	logic [5:0] cnt_q; // clocks since supplies settled
	// por low from time zero, before supplies ramp
	initial por_n_out = 1'b0;
	// straps set long before por release
	assign src_out = src_in;
	assign div_out = div_in;
	// por held 33 clocks once supplies settle
	always @(negedge ref_clk_in)
	begin
		if (!go_in)
		begin
			cnt_q     <= 6'h00;
			por_n_out <= 1'b0;
		end
		else if (cnt_q < 6'h20)
			cnt_q <= cnt_q + 6'h01;
		else
			por_n_out <= 1'b1;
	end
endmodule : board_supervisor

// ---- sim/por_reset_sequencer_tb_top.sv ----
// testbench for the power-on reset sequencer
// assumes the board model drives por and straps
`timescale 1ns/1ps
module por_reset_sequencer_tb_top;
	localparam int unsigned PW = 20; // shortened pll wait
	logic       ref_clk_in; // 20 MHz clock
	logic       arst_n_in;  // async reset
	logic       go;         // supplies stable
	logic [2:0] src;        // wanted source straps
	logic       div;        // wanted divide strap
	logic [3:0] drv;        // strap redrive value
	logic       por_n;      // supervisor por
	logic [2:0] src_pin;    // source strap level
	logic       div_pin;    // divide strap level
	logic       hard_oe;    // hard reset pulled
	logic       soft_oe;    // soft reset pulled
	logic [3:0] cfg_pins;   // strap redrive
	logic       cfg_oe;     // strap pins driven
	logic [2:0] src_lat;    // latched source
	logic       div_lat;    // latched divide
	logic       pll_lk;     // pll wait over
	logic       en;         // clock enable
	logic       hard_lvl;   // hard reset pin level
	logic       soft_lvl;   // soft reset pin level
	logic [4:0] obs;        // watched levels
	int         num_errors;
	int         n_compared;
	assign obs = {por_n, cfg_oe, soft_oe, hard_oe, pll_lk};
	// free-running clock, 50 ns period
	initial ref_clk_in = 1'b0;
	always #25 ref_clk_in = ~ref_clk_in;
	board_supervisor board_supervisor_i (.ref_clk_in(ref_clk_in),
		.go_in(go), .src_in(src), .div_in(div), .por_n_out(por_n),
		.src_out(src_pin), .div_out(div_pin));
	por_reset_sequencer #(.PLL_WAIT(PW)) por_reset_sequencer_i (
		.ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in), .clk_en_in(en),
		.power_on_reset_n_in(por_n), .reset_source_select_in(src_pin),
		.input_clock_divide_cfg_in(div_pin), .cfg_drive_val_in(drv),
		.hard_reset_n_out(hard_lvl), .hard_reset_n_oe_out(hard_oe),
		.soft_reset_n_out(soft_lvl), .soft_reset_n_oe_out(soft_oe),
		.cfg_pins_out(cfg_pins), .cfg_pins_oe_out(cfg_oe),
		.reset_source_out(src_lat), .clock_divide_out(div_lat),
		.pll_locked_out(pll_lk));
	// verdict and end of run
	task automatic final_report;
		$display("compared %0d, mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : final_report
	// checks a value lies in lo..hi
	task automatic rng(input logic [31:0] v, lo, hi);
		n_compared++;
		if ((v >= lo && v <= hi) !== 1'b1)
		begin
			num_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, v, lo);
		end
	endtask : rng
	// waits for obs bit to reach lvl; strap pins must stay free while hard reset is pulled
	task automatic wait_obs(input int b, input logic lvl, output int n);
		n = 0;
		while (obs[b] !== lvl && n < 3000)
		begin
			@(negedge ref_clk_in);
			n++;
			rng(32'(hard_oe & cfg_oe), 0, 0);
		end
		if (n >= 3000)
		begin
			num_errors++;
			final_report();
		end
	endtask : wait_obs
	// whole power-up; straps moved after capture
	task automatic full_seq(input logic [2:0] s, input logic d);
		int n;
		int r;
		r = d ? 2 : 1;
		src <= s;
		div <= d;
		drv <= {s, d};
		go <= 1'b1;
		wait_obs(4, 1'b1, n);
		wait_obs(0, 1'b1, n);
		rng(n, PW, PW + 4);
		rng(32'({hard_lvl, soft_lvl}), 0, 0);
		src <= ~s;
		div <= ~d;
		wait_obs(1, 1'b0, n);
		rng(n, 512 * r, 512 * r + 2 * r + 2);
		wait_obs(2, 1'b0, n);
		rng(n, 16 * r, 17 * r + 2);
		wait_obs(3, 1'b1, n);
		rng(n, r, r + 2);
		rng(32'(cfg_pins), 32'(drv), 32'(drv));
		rng(32'({src_lat, div_lat}), 32'({s, d}), 32'({s, d}));
		go <= 1'b0;
		wait_obs(1, 1'b1, n);
		rng(n, 1, 3);
		rng(32'(cfg_oe), 0, 0);
	endtask : full_seq
	// por dropped mid hard reset: frozen while enable low, then restart
	task automatic abort_seq;
		int n;
		go <= 1'b1;
		wait_obs(0, 1'b1, n);
		repeat (100) @(negedge ref_clk_in);
		en <= 1'b0;
		go <= 1'b0;
		wait_obs(4, 1'b0, n);
		repeat (8) @(negedge ref_clk_in);
		rng(32'(obs), 32'h07, 32'h07);
		en <= 1'b1;
		repeat (2) @(negedge ref_clk_in);
		rng(32'(obs[3:0]), 32'h6, 32'h6);
	endtask : abort_seq
	// main sequence
	initial
	begin
		num_errors = 0;
		n_compared = 0;
		arst_n_in = 1'b0;
		go = 1'b0;
		src = 3'h0;
		div = 1'b0;
		drv = 4'hA;
		en = 1'b1;
		repeat (12) @(negedge ref_clk_in);
		rng(32'({src_lat, obs[3:0]}), 32'h6, 32'h6);
		arst_n_in = 1'b1;
		repeat (4) @(negedge ref_clk_in);
		full_seq(3'h5, 1'b0);
		abort_seq();
		full_seq(3'h2, 1'b1);
		final_report();
	end
endmodule : por_reset_sequencer_tb_top
